// ==== logic/ssw_pkg.sv ====
package ssw_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 100000000;
    localparam int unsigned TICK_HZ = 1000;
    localparam int unsigned TICK_DIV = CLK_FREQ_HZ / TICK_HZ;
    localparam int unsigned RESET_STRETCH_MS = 200;
    localparam int unsigned WDOG_TIMEOUT_MS = 1600;
    localparam int unsigned RESET_STRETCH_TICKS =
        RESET_STRETCH_MS * TICK_HZ / 1000;
    localparam int unsigned WDOG_TIMEOUT_TICKS =
        WDOG_TIMEOUT_MS * TICK_HZ / 1000;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned TICK_CNT_W = 32;

    // ------------------------------------------------------------------
    // Reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSW_ST_HOLD = 3'h1,
        SSW_ST_RUN = 3'h2,
        SSW_ST_PULSE = 3'h4
    } ssw_state_t;

    // Three-level service input encoding
    localparam logic [1:0] WDI_LOW = 2'h0;
    localparam logic [1:0] WDI_HIGH = 2'h1;
    localparam logic [1:0] WDI_FLOAT = 2'h2;
endpackage

// ==== logic/ssw_tick_div.sv ====
`timescale 1ns/1ps
module ssw_tick_div #(
    parameter int unsigned DIV = ssw_pkg::TICK_DIV
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    // ------------------------------------------------------------------
    // Time base divider
    // ------------------------------------------------------------------
    logic [ssw_pkg::TICK_CNT_W-1:0] cnt_reg;
    logic [ssw_pkg::TICK_CNT_W-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    localparam logic [ssw_pkg::TICK_CNT_W-1:0] LAST =
        ssw_pkg::TICK_CNT_W'(DIV - 1);

    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= LAST) begin
            cnt_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ==== logic/ssw_supervisor.sv ====
`timescale 1ns/1ps
// Operation
// - Reset output low while supply is below the reset threshold.
// - Keep reset low 200 ms after supply recovers above threshold.
// - Reset stays low throughout power-down.
// - Optional active-high reset, always the complement of active-low reset.
// - Enabled watchdog pulses reset when no service edge within 1.6 s.
// - Any service input edge, rising or falling, restarts the timeout.
// - Constant service level gives a fresh reset pulse 1.6 s after each pulse ends.
// - Each watchdog reset holds active-low reset for 200 ms.
// - Floating or mid-supply service input disables the watchdog.
// - Supply above threshold selects main supply onto backed output.
// - Below threshold, battery selected only if higher than main.
// - Battery mode disables watchdog and holds reset asserted.
// - Battery mode disables power-fail compare, warning forced low.
// - Normally warning low when sense is below the 1.25 V reference.
// - Missing or floating battery never causes reset while supply good.
module ssw_supervisor #(
    parameter int unsigned TICK_DIV = ssw_pkg::TICK_DIV,
    parameter int unsigned STRETCH_TICKS = ssw_pkg::RESET_STRETCH_TICKS,
    parameter int unsigned TIMEOUT_TICKS = ssw_pkg::WDOG_TIMEOUT_TICKS,
    parameter bit ACTIVE_HIGH_RESET = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic supply_below_threshold,
    input wire logic battery_above_main,
    input wire logic power_fail_sense,
    input wire logic watchdog_service_input,
    input wire logic watchdog_service_float,
    output logic system_reset_n,
    output logic system_reset,
    output logic power_fail_warning_low,
    output logic backed_supply_output
);
    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic tick;

    ssw_tick_div #(
        .DIV(TICK_DIV)
    ) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Counter limits
    // ------------------------------------------------------------------
    localparam logic [ssw_pkg::CNT_W-1:0] STRETCH_LAST =
        ssw_pkg::CNT_W'(STRETCH_TICKS - 1);
    localparam logic [ssw_pkg::CNT_W-1:0] TIMEOUT_LAST =
        ssw_pkg::CNT_W'(TIMEOUT_TICKS - 1);

    // ------------------------------------------------------------------
    // Service input decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] wdi_level(input logic lvl,
                                             input logic flt);
        if (flt) begin
            wdi_level = ssw_pkg::WDI_FLOAT;
        end else if (lvl) begin
            wdi_level = ssw_pkg::WDI_HIGH;
        end else begin
            wdi_level = ssw_pkg::WDI_LOW;
        end
    endfunction

    function automatic logic is_driven(input logic [1:0] code);
        is_driven = (code != ssw_pkg::WDI_FLOAT);
    endfunction

    function automatic logic at_last(input logic [ssw_pkg::CNT_W-1:0] cnt,
                                     input logic [ssw_pkg::CNT_W-1:0] last);
        at_last = (cnt >= last);
    endfunction

    // ------------------------------------------------------------------
    // Supply mode and switchover
    // ------------------------------------------------------------------
    logic battery_mode;
    logic [1:0] wdi_now;
    logic wdog_enabled;

    always_comb begin
        // Battery only wins when it is really higher than main
        battery_mode = supply_below_threshold && battery_above_main;
        wdi_now = wdi_level(watchdog_service_input, watchdog_service_float);
        wdog_enabled = is_driven(wdi_now)
            && !battery_mode;
    end

    // ------------------------------------------------------------------
    // Service edge detector
    // ------------------------------------------------------------------
    // Starts at the float code, so the first level after reset is no edge
    logic [1:0] wdi_last_reg;
    logic [1:0] wdi_last_next;
    logic wdi_edge;

    always_comb begin
        wdi_last_next = wdi_now;
        // Either edge direction counts as service
        wdi_edge = (wdi_now != wdi_last_reg) && is_driven(wdi_now)
            && is_driven(wdi_last_reg);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdi_last_reg <= ssw_pkg::WDI_FLOAT;
        end else begin
            wdi_last_reg <= wdi_last_next;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog timeout counter
    // ------------------------------------------------------------------
    ssw_pkg::ssw_state_t state_reg;
    ssw_pkg::ssw_state_t state_next;
    logic [ssw_pkg::CNT_W-1:0] wdog_reg;
    logic [ssw_pkg::CNT_W-1:0] wdog_next;
    logic wdog_expired;

    // Counts only in run, so each entry to run opens a fresh window
    // A stuck level is caught within one tick of the nominal window
    always_comb begin
        wdog_next = wdog_reg;
        if (!wdog_enabled || wdi_edge
            || state_reg != ssw_pkg::SSW_ST_RUN) begin
            wdog_next = '0;
        end else if (tick) begin
            wdog_next = wdog_reg + 1'b1;
        end
        wdog_expired = wdog_enabled && tick && !wdi_edge
            && at_last(wdog_reg, TIMEOUT_LAST);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdog_reg <= '0;
        end else begin
            wdog_reg <= wdog_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset stretch counter
    // ------------------------------------------------------------------
    logic [ssw_pkg::CNT_W-1:0] stretch_reg;
    logic [ssw_pkg::CNT_W-1:0] stretch_next;
    logic stretch_done;

    // One counter times both the power-up stretch and the watchdog pulse
    // Supply low parks the count, so reset stays low all through power-down
    always_comb begin
        stretch_next = stretch_reg;
        stretch_done = !supply_below_threshold && tick
            && at_last(stretch_reg, STRETCH_LAST);
        if (supply_below_threshold || stretch_done
            || state_reg == ssw_pkg::SSW_ST_RUN) begin
            stretch_next = '0;
        end else if (tick) begin
            stretch_next = stretch_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stretch_reg <= '0;
        end else begin
            stretch_reg <= stretch_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ssw_pkg::SSW_ST_HOLD: begin
                if (stretch_done) begin
                    state_next = ssw_pkg::SSW_ST_RUN;
                end
            end
            ssw_pkg::SSW_ST_RUN: begin
                // Battery state has no say here, only the main supply
                if (supply_below_threshold) begin
                    state_next = ssw_pkg::SSW_ST_HOLD;
                end else if (wdog_expired) begin
                    state_next = ssw_pkg::SSW_ST_PULSE;
                end
            end
            ssw_pkg::SSW_ST_PULSE: begin
                // A supply drop always wins over a pulse in progress
                if (supply_below_threshold) begin
                    state_next = ssw_pkg::SSW_ST_HOLD;
                end else if (stretch_done) begin
                    // Timeout restarts, so a stuck line pulses again
                    state_next = ssw_pkg::SSW_ST_RUN;
                end
            end
            default: begin
                state_next = ssw_pkg::SSW_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ssw_pkg::SSW_ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------------
    logic reset_n_reg;
    logic reset_n_next;
    logic reset_reg;
    logic reset_next;

    always_comb begin
        // Outputs follow the next state, so nothing combinational reaches a pin
        reset_n_next = (state_next == ssw_pkg::SSW_ST_RUN);
        if (ACTIVE_HIGH_RESET) begin
            reset_next = !reset_n_next;
        end else begin
            reset_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_n_reg <= 1'b0;
            reset_reg <= ACTIVE_HIGH_RESET;
        end else begin
            reset_n_reg <= reset_n_next;
            reset_reg <= reset_next;
        end
    end

    // ------------------------------------------------------------------
    // Power-fail warning
    // ------------------------------------------------------------------
    logic pfw_reg;
    logic pfw_next;

    always_comb begin
        // Comparator is off in backup, so the pin is parked low
        if (battery_mode) begin
            pfw_next = 1'b0;
        end else begin
            pfw_next = power_fail_sense;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pfw_reg <= 1'b0;
        end else begin
            pfw_reg <= pfw_next;
        end
    end

    // ------------------------------------------------------------------
    // Backed supply switch
    // ------------------------------------------------------------------
    logic backed_supply_output_reg;
    logic backed_supply_output_next;

    always_comb begin
        // Main stays on unless the battery is both needed and higher
        if (battery_mode) begin
            backed_supply_output_next = 1'b1;
        end else begin
            backed_supply_output_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            backed_supply_output_reg <= 1'b0;
        end else begin
            backed_supply_output_reg <= backed_supply_output_next;
        end
    end

    assign system_reset_n = reset_n_reg;
    assign system_reset = reset_reg;
    assign power_fail_warning_low = pfw_reg;
    assign backed_supply_output = backed_supply_output_reg;
endmodule

// ==== tb/ssw_supervisor_sva.sv ====
`timescale 1ns/1ps
module ssw_supervisor_sva #(
    parameter bit ACTIVE_HIGH_RESET = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic supply_below_threshold,
    input wire logic battery_above_main,
    input wire logic power_fail_sense,
    input wire logic watchdog_service_float,
    input wire logic system_reset_n,
    input wire logic system_reset,
    input wire logic power_fail_warning_low,
    input wire logic backed_supply_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic low = supply_below_threshold;
    wire logic bm = low && battery_above_main;
    // Shortest legal stretch, less one tick of jitter
    sequence s_held;
        !system_reset_n [*8];
    endsequence
    a_supply_low: assert property (low |=> !system_reset_n)
        else $error("reset high with supply low");
    a_reset_pair: assert property (
        system_reset == (ACTIVE_HIGH_RESET ? !system_reset_n : 1'b0))
        else $error("reset outputs disagree");
    a_stretch_hold: assert property ($fell(low) |-> s_held)
        else $error("stretch too short");
    a_bite_width: assert property ($fell(system_reset_n) |-> s_held)
        else $error("reset pulse too short");
    a_warn_follow: assert property (
        !bm |=> power_fail_warning_low == $past(power_fail_sense))
        else $error("warning does not follow sense");
    a_battery_mode: assert property (bm |=>
        !power_fail_warning_low && backed_supply_output && !system_reset_n)
        else $error("battery mode outputs wrong");
    a_main_select: assert property (!bm |=> !backed_supply_output)
        else $error("battery selected while main good");
    a_float_quiet: assert property (
        system_reset_n && !low && watchdog_service_float |=> system_reset_n)
        else $error("reset while watchdog off");
endmodule
bind ssw_supervisor ssw_supervisor_sva #(
    .ACTIVE_HIGH_RESET(ACTIVE_HIGH_RESET)
) ssw_supervisor_sva_inst (
    .core_clk(core_clk),
    .rst(rst),
    .supply_below_threshold(supply_below_threshold),
    .battery_above_main(battery_above_main),
    .power_fail_sense(power_fail_sense),
    .watchdog_service_float(watchdog_service_float),
    .system_reset_n(system_reset_n),
    .system_reset(system_reset),
    .power_fail_warning_low(power_fail_warning_low),
    .backed_supply_output(backed_supply_output)
);

// ==== tb/ssw_cpu_model.sv ====
`timescale 1ns/1ps
module ssw_cpu_model #(
    parameter int PERIOD = 12
) (
    input wire logic core_clk,
    input wire logic system_reset_n,
    input wire logic [1:0] mode,
    output logic svc,
    output logic flt
);
    int cnt = 0;
    initial begin
        svc = 1'b0;
        flt = 1'b0;
    end
    // Mode 0 services, 1 stalls, 2 three-states the line
    always @(posedge core_clk) begin
        cnt <= #1 (cnt >= PERIOD - 1 || !system_reset_n) ? 0 : cnt + 1;
        flt <= #1 (mode == 2'h2);
        if (mode == 2'h2) begin
            svc <= #1 ~svc; // Released line holds no stable level
        end else if (mode == 2'h0 && cnt == PERIOD - 1) begin
            svc <= #1 ~svc;
        end
    end
endmodule

// ==== tb/ssw_supervisor_test.sv ====
`timescale 1ns/1ps
module ssw_supervisor_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sup = 1'b1;
    logic bat = 1'b0;
    logic pfs = 1'b1;
    logic [1:0] mode = 2'h0;
    logic svc, flt, rn, rh, pfw, bso;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    ssw_supervisor #(.TICK_DIV(4), .STRETCH_TICKS(3), .TIMEOUT_TICKS(5))
    ssw_supervisor_inst (.core_clk(core_clk), .rst(rst),
        .supply_below_threshold(sup), .battery_above_main(bat),
        .power_fail_sense(pfs), .watchdog_service_input(svc),
        .watchdog_service_float(flt), .system_reset_n(rn),
        .system_reset(rh), .power_fail_warning_low(pfw),
        .backed_supply_output(bso));
    ssw_cpu_model ssw_cpu_model_inst (.core_clk(core_clk),
        .system_reset_n(rn), .mode(mode), .svc(svc), .flt(flt));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    task check(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task close_out;
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Counts cycles until reset reaches v; 60 means it never did
    task wait_rn(input logic v);
        n = 0;
        while (rn !== v && n < 60) begin
            step(1);
            n++;
        end
    endtask
    task t_power_up;
        check(rn, 1'b0, "reset with supply low");
        check(rh, 1'b1, "active-high reset");
        sup = 1'b0;
        wait_rn(1'b1);
        check(n >= 8 && n <= 18, 1'b1, "stretch length");
        check(rh, 1'b0, "active-high release");
        $display("power-up done");
    endtask
    task t_quiet;
        wait_rn(1'b0);
        check(n == 60, 1'b1, "serviced watchdog bit");
        mode = 2'h2;
        bat = 1'b1;
        wait_rn(1'b0);
        check(n == 60, 1'b1, "disabled watchdog bit");
        check(bso, 1'b0, "main kept while good");
        bat = 1'b0;
        mode = 2'h0;
        $display("quiet done");
    endtask
    task t_stall;
        mode = 2'h1;
        wait_rn(1'b0);
        check(n >= 16 && n <= 26, 1'b1, "timeout length");
        wait_rn(1'b1);
        check(n >= 8 && n <= 18, 1'b1, "pulse length");
        wait_rn(1'b0);
        check(n >= 16 && n <= 26, 1'b1, "repeat pulse");
        mode = 2'h0;
        wait_rn(1'b1);
        $display("stall done");
    endtask
    task t_battery;
        pfs = 1'b0;
        step(2);
        check(pfw, 1'b0, "warning on low sense");
        pfs = 1'b1;
        sup = 1'b1;
        step(1);
        check(pfw, 1'b1, "warning clear");
        check(rn, 1'b0, "brownout reset");
        check(bso, 1'b0, "battery lower than main");
        bat = 1'b1;
        mode = 2'h1;
        step(1);
        check(bso, 1'b1, "battery selected");
        check(pfw, 1'b0, "warning forced low");
        step(40);
        check(rh, 1'b1, "reset held in backup");
        bat = 1'b0;
        sup = 1'b0;
        mode = 2'h0;
        step(1);
        check(bso, 1'b0, "main restored");
        wait_rn(1'b1);
        check(n >= 7 && n <= 18, 1'b1, "stretch after backup");
        $display("battery done");
    endtask
    initial begin
        step(10);
        rst = 1'b0;
        step(3);
        t_power_up();
        t_quiet();
        t_stall();
        t_battery();
        close_out();
    end
endmodule
